// ---- pkg/uart_map_pkg.sv ----
// Purpose: constants and types of the eight-channel memory window decoder
// Assumes: 32-bit host bus, byte enables active high, 4K window
// Notes:   slice offsets are byte offsets inside one 512-byte channel slice
package uart_map_pkg;
  localparam int          CHANNELS        = 8;
  localparam int          WINDOW_BITS     = 12;
  localparam int          SLICE_BITS      = 9;
  localparam int          QUEUE_BYTES     = 64;
  localparam logic [8:0]  REG_FIRST       = 9'h000;
  localparam logic [8:0]  REG_LAST        = 9'h00f;
  localparam logic [8:0]  CFG_FIRST       = 9'h080;
  localparam logic [8:0]  CFG_LAST        = 9'h093;
  localparam logic [8:0]  QUEUE_FIRST     = 9'h100;
  localparam logic [8:0]  QUEUE_LAST      = 9'h13f;
  localparam logic [8:0]  ERRQ_FIRST      = 9'h180;
  localparam logic [8:0]  ERRQ_LAST       = 9'h1ff;
  localparam logic [2:0]  CFG_CHANNEL     = 3'h0;
  localparam logic [3:0]  BE_LOW_HALF     = 4'h3;
  localparam logic [3:0]  BE_HIGH_HALF    = 4'hc;
  localparam logic [3:0]  BE_FULL         = 4'hf;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

  typedef enum logic [2:0]
  {
    KIND_NONE  = 3'h0,
    KIND_REG   = 3'h1,
    KIND_CFG   = 3'h2,
    KIND_RXQ   = 3'h3,
    KIND_TXQ   = 3'h4,
    KIND_RXERR = 3'h5
  } access_kind_t;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_ISSUE  = 2'b01,
    ST_ANSWER = 2'b11
  } cycle_state_t;
endpackage : uart_map_pkg

// ---- pkg/lane_info_if.sv ----
// Purpose: byte-enable summary passed from the lane analyser to the decoder
// Assumes: one 32-bit data path, four byte lanes
// Notes:   analyser drives, decoder reads
`timescale 1ns/1ps
interface lane_info_if;
  logic [3:0] be;
  logic [2:0] count;
  logic [1:0] first;
  logic       contig;

  modport analyser
  (
    input  be,
    output count,
    output first,
    output contig
  );
  modport user
  (
    output be,
    input  count,
    input  first,
    input  contig
  );
endinterface : lane_info_if

// ---- design/lane_analyser.sv ----
// Purpose: counts enabled byte lanes, finds the lowest, checks they are adjacent
// Assumes: byte enables active high
// Notes:   an empty enable set counts as not contiguous
`timescale 1ns/1ps
module lane_analyser
(
  lane_info_if.analyser lanes
);
  always_comb
  begin
    lanes.count  = 3'(lanes.be[0]) + 3'(lanes.be[1]) + 3'(lanes.be[2]) + 3'(lanes.be[3]);
    lanes.first  = lanes.be[0] ? 2'd0 : lanes.be[1] ? 2'd1 : lanes.be[2] ? 2'd2 : 2'd3;
    case (lanes.be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf: lanes.contig = 1'b1;
      default:                                                     lanes.contig = 1'b0;
    endcase
  end
endmodule : lane_analyser

// ---- design/uart_window_decoder.sv ----
// Purpose: decodes the 4K memory window of an eight-channel serial device
// Assumes: single request outstanding; queues and registers live outside
// Notes:   request taken in idle, target cycle next, answer one cycle later
// Notes on behaviour
// - slice offsets 0x000-0x00F reach channel registers
// - reads at 0x100-0x13F pop receive queue bytes
// - writes at 0x100-0x13F push transmit queue bytes
// - error window read-only, 16 or 32 bits
// - error window pairs data with line status
// - eight slices repeat at 0x200 stride
// - device configuration only in channel zero slice
// - queue pointers advance by bytes transferred, by half that in the error window
// - 4K window placed by programmed base address
`timescale 1ns/1ps
module uart_window_decoder
  import uart_map_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [19:0] base_addr_in,
  input  wire logic        mem_enable_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  output logic             req_hit_out,
  input  wire logic        req_write_in,
  input  wire logic [31:2] req_addr_in,
  input  wire logic [3:0]  req_be_in,
  input  wire logic [31:0] req_wdata_in,
  output logic             resp_valid_out,
  output logic [31:0]      resp_rdata_out,
  output logic             resp_misuse_out,
  output logic             tgt_valid_out,
  output logic [2:0]       tgt_kind_out,
  output logic [2:0]       tgt_chan_out,
  output logic [8:0]       tgt_offset_out,
  output logic             tgt_write_out,
  output logic [3:0]       tgt_be_out,
  output logic [31:0]      tgt_wdata_out,
  input  wire logic [31:0] tgt_rdata_in,
  output logic [7:0]       rx_pop_out,
  output logic [2:0]       rx_pop_count_out,
  input  wire logic [31:0] rx_bytes_in,
  input  wire logic [31:0] line_status_value_in,
  output logic [7:0]       tx_push_out,
  output logic [2:0]       tx_push_count_out,
  output logic [31:0]      tx_bytes_out
);
  // refuse a package whose slices do not tile the window
  if (CHANNELS * (1 << SLICE_BITS) != (1 << WINDOW_BITS))
  begin : g_bad_window
    $error("channel slices do not fill the window");
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane analysis
  lane_info_if lanes ();
  lane_analyser u_lanes
  (
    .lanes (lanes)
  );
  assign lanes.be = req_be_in;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic [8:0]   slice_off;
  logic [2:0]   chan;
  logic         hit;
  logic         legal;
  access_kind_t kind;

  assign slice_off = {req_addr_in[8:2], 2'b00} + 9'(lanes.first);
  assign chan      = req_addr_in[11:9];
  assign hit       = mem_enable_in && (req_addr_in[31:WINDOW_BITS] == base_addr_in);

  always_comb
  begin
    kind  = KIND_NONE;
    legal = lanes.contig;
    if (slice_off >= REG_FIRST && slice_off <= REG_LAST)
      kind = KIND_REG;
    else if (chan == CFG_CHANNEL && slice_off >= CFG_FIRST && slice_off <= CFG_LAST)
      kind = KIND_CFG;
    else if (slice_off >= QUEUE_FIRST && slice_off <= QUEUE_LAST)
      kind = req_write_in ? KIND_TXQ : KIND_RXQ;
    else if (slice_off >= ERRQ_FIRST && slice_off <= ERRQ_LAST)
    begin
      kind  = KIND_RXERR;
      legal = !req_write_in &&
              (req_be_in == BE_LOW_HALF || req_be_in == BE_HIGH_HALF || req_be_in == BE_FULL);
    end
    if (!legal)
      kind = KIND_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle control
  cycle_state_t state_reg;
  cycle_state_t state_next;
  logic         take;

  assign req_ready_out = (state_reg == ST_IDLE);
  assign req_hit_out   = req_ready_out && hit;
  assign take          = req_valid_in && req_ready_out && hit;

  always_comb
  begin
    case (state_reg)
      ST_IDLE:   state_next = take ? ST_ISSUE : ST_IDLE;
      ST_ISSUE:  state_next = ST_ANSWER;
      ST_ANSWER: state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // captured request
  access_kind_t kind_reg,   kind_next;
  logic [2:0]   chan_reg,   chan_next;
  logic [8:0]   off_reg,    off_next;
  logic         write_reg,  write_next;
  logic [3:0]   be_reg,     be_next;
  logic [31:0]  wdata_reg,  wdata_next;
  logic [1:0]   first_reg,  first_next;
  logic [2:0]   count_reg,  count_next;
  logic         misuse_reg, misuse_next;

  always_comb
  begin
    kind_next   = kind_reg;
    chan_next   = chan_reg;
    off_next    = off_reg;
    write_next  = write_reg;
    be_next     = be_reg;
    wdata_next  = wdata_reg;
    first_next  = first_reg;
    count_next  = count_reg;
    misuse_next = misuse_reg;
    if (take)
    begin
      kind_next   = kind;
      chan_next   = chan;
      off_next    = {req_addr_in[8:2], 2'b00};
      write_next  = req_write_in;
      be_next     = req_be_in;
      wdata_next  = req_wdata_in;
      first_next  = lanes.first;
      count_next  = lanes.count;
      misuse_next = (kind == KIND_NONE);
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      kind_reg   <= KIND_NONE;
      chan_reg   <= 3'h0;
      off_reg    <= 9'h000;
      write_reg  <= 1'b0;
      be_reg     <= 4'h0;
      wdata_reg  <= RDATA_RESET;
      first_reg  <= 2'd0;
      count_reg  <= 3'd0;
      misuse_reg <= 1'b0;
    end
    else
    begin
      kind_reg   <= kind_next;
      chan_reg   <= chan_next;
      off_reg    <= off_next;
      write_reg  <= write_next;
      be_reg     <= be_next;
      wdata_reg  <= wdata_next;
      first_reg  <= first_next;
      count_reg  <= count_next;
      misuse_reg <= misuse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // target strobes
  logic issue;
  logic is_rx;
  logic [7:0] chan_onehot;

  assign issue       = (state_reg == ST_ISSUE);
  assign is_rx       = (kind_reg == KIND_RXQ) || (kind_reg == KIND_RXERR);
  assign chan_onehot = 8'h01 << chan_reg;

  assign tgt_valid_out     = issue && (kind_reg == KIND_REG || kind_reg == KIND_CFG);
  assign tgt_kind_out      = kind_reg;
  assign tgt_chan_out      = chan_reg;
  assign tgt_offset_out    = off_reg;
  assign tgt_write_out     = write_reg;
  assign tgt_be_out        = be_reg;
  assign tgt_wdata_out     = wdata_reg;
  assign rx_pop_out        = (issue && is_rx) ? chan_onehot : 8'h00;
  assign rx_pop_count_out  = (kind_reg == KIND_RXERR) ? (count_reg >> 1) : count_reg;
  assign tx_push_out       = (issue && kind_reg == KIND_TXQ) ? chan_onehot : 8'h00;
  assign tx_push_count_out = count_reg;
  assign tx_bytes_out      = wdata_reg >> {first_reg, 3'b000};

  ////////////////////////////////////////////////////////////////////////////
  // read data assembly, one lane per loop pass
  logic [31:0] lane_data;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      logic [1:0] qidx;
      logic [1:0] pidx;
      assign qidx = 2'(lane) - first_reg;
      assign pidx = 2'(lane / 2) - {1'b0, first_reg[1]};
      always_comb
      begin
        case (kind_reg)
          KIND_REG, KIND_CFG: lane_data[lane*8 +: 8] = tgt_rdata_in[lane*8 +: 8];
          KIND_RXQ:           lane_data[lane*8 +: 8] = rx_bytes_in[qidx*8 +: 8];
          KIND_RXERR:         lane_data[lane*8 +: 8] = (lane % 2 == 0) ? rx_bytes_in[pidx*8 +: 8]
                                                                       : line_status_value_in[pidx*8 +: 8];
          default:            lane_data[lane*8 +: 8] = 8'h00;
        endcase
        if (!be_reg[lane] || write_reg)
          lane_data[lane*8 +: 8] = 8'h00;
      end
    end
  endgenerate

  always_comb
  begin
    rdata_next = issue ? lane_data : rdata_reg;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      rdata_reg <= RDATA_RESET;
    else
      rdata_reg <= rdata_next;
  end

  assign resp_valid_out  = (state_reg == ST_ANSWER);
  assign resp_rdata_out  = rdata_reg;
  assign resp_misuse_out = resp_valid_out && misuse_reg;
endmodule : uart_window_decoder

// ---- dv/uart_window_decoder_assertions.sv ----
// Purpose: port timing checks of the window decoder
// Assumes: one clock, synchronous active-low reset
// Notes:   bound below to every decoder instance
`timescale 1ns/1ps
module uart_window_decoder_chk
  import uart_map_pkg::*;
(
  input logic        sys_clk_in,
  input logic        rst_n_in,
  input logic [19:0] base_addr_in,
  input logic        mem_enable_in,
  input logic        req_valid_in,
  input logic        req_ready_out,
  input logic        req_hit_out,
  input logic        req_write_in,
  input logic [31:2] req_addr_in,
  input logic        resp_valid_out,
  input logic [31:0] resp_rdata_out,
  input logic        resp_misuse_out,
  input logic        tgt_valid_out,
  input logic [2:0]  tgt_kind_out,
  input logic [2:0]  tgt_chan_out,
  input logic        tgt_write_out,
  input logic [7:0]  rx_pop_out,
  input logic [2:0]  rx_pop_count_out,
  input logic [7:0]  tx_push_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire take = req_valid_in && req_ready_out && req_hit_out;
  AST_ANSWER: assert property (take |-> ##2 resp_valid_out)
    else $error("no answer two cycles after take");
  AST_MISS: assert property (!mem_enable_in || req_addr_in[31:12] != base_addr_in |-> !req_hit_out)
    else $error("hit outside window");
  AST_POP: assert property (|rx_pop_out |-> rx_pop_out == 8'h01 << tgt_chan_out && !tgt_write_out)
    else $error("pop on wrong channel or on write");
  AST_PUSH: assert property (|tx_push_out |-> tx_push_out == 8'h01 << tgt_chan_out
    && tgt_kind_out == KIND_TXQ) else $error("push on wrong channel or kind");
  AST_ERR_WRITE: assert property (take && req_write_in && req_addr_in[8:7] == 2'b11
    |=> rx_pop_out == 8'h00 && tx_push_out == 8'h00 ##1 resp_misuse_out) else $error("write to error window acted");
  AST_CFG: assert property (tgt_valid_out && tgt_kind_out == KIND_CFG |-> tgt_chan_out == CFG_CHANNEL)
    else $error("config decoded outside channel zero");
  AST_ZERO: assert property (resp_misuse_out |-> resp_valid_out && resp_rdata_out == 32'h0000_0000)
    else $error("misuse answer not zero");
  AST_PAIRS: assert property (|rx_pop_out && tgt_kind_out == KIND_RXERR
    |-> rx_pop_count_out inside {3'h1, 3'h2}) else $error("bad pair count");
  AST_COUNT: assert property (|rx_pop_out && tgt_kind_out == KIND_RXQ
    |-> rx_pop_count_out inside {[3'h1:3'h4]}) else $error("bad pop count");
endmodule : uart_window_decoder_chk
bind uart_window_decoder uart_window_decoder_chk u_chk (.sys_clk_in, .rst_n_in, .base_addr_in, .mem_enable_in,
  .req_valid_in, .req_ready_out, .req_hit_out, .req_write_in, .req_addr_in, .resp_valid_out, .resp_rdata_out,
  .resp_misuse_out, .tgt_valid_out, .tgt_kind_out, .tgt_chan_out, .tgt_write_out, .rx_pop_out, .rx_pop_count_out,
  .tx_push_out);

// ---- dv/queue_side_model.sv ----
// Purpose: queues and registers behind the decoder
// Assumes: receive pointers move on pops only
// Notes:   byte value is low two channel bits and queue position
`timescale 1ns/1ps
module queue_side_model
(
  input  logic        sys_clk_in,
  input  logic [2:0]  tgt_chan_in,
  input  logic [8:0]  tgt_offset_in,
  input  logic [7:0]  rx_pop_in,
  input  logic [2:0]  rx_pop_count_in,
  output logic [31:0] tgt_rdata_out,
  output logic [31:0] rx_bytes_out,
  output logic [31:0] line_status_out
);
  logic [5:0] ptr_reg [8] = '{default: 6'h00};
  always_ff @(posedge sys_clk_in)
    if (|rx_pop_in)
      ptr_reg[tgt_chan_in] <= ptr_reg[tgt_chan_in] + 6'(rx_pop_count_in);
  always_comb
    for (int k = 0; k < 4; k++)
      rx_bytes_out[8*k +: 8] = {tgt_chan_in[1:0], 6'(ptr_reg[tgt_chan_in] + k)};
  assign line_status_out = ~rx_bytes_out;
  assign tgt_rdata_out = {20'h5a5a5, tgt_chan_in, tgt_offset_in};
endmodule : queue_side_model

// ---- dv/tb_octal_uart_memory_map_decoder.sv ----
// Purpose: self-checking bench of the window decoder
// Assumes: one request at a time
// Notes:   expected queue bytes follow the model's pattern
`timescale 1ns/1ps
module tb_octal_uart_memory_map_decoder import uart_map_pkg::*;;
  logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, mem_enable_in = 1'b1, req_valid_in = 1'b0, req_write_in = 1'b0;
  logic [19:0] base_addr_in = 20'hfeb00;
  logic [31:2] req_addr_in = '0;
  logic [3:0]  req_be_in = '0, tgt_be_out;
  logic [31:0] req_wdata_in = '0, resp_rdata_out, tgt_rdata_in, rx_bytes_in, line_status_value_in, tgt_wdata_out;
  logic [31:0] tx_bytes_out, g_rd, g_tx, g_wd;
  logic [17:0] g_tgt;
  logic        req_ready_out, req_hit_out, resp_valid_out, resp_misuse_out, tgt_valid_out, tgt_write_out, g_mis;
  logic [2:0]  tgt_kind_out, tgt_chan_out, rx_pop_count_out, tx_push_count_out, g_kind, g_pc, g_tc;
  logic [8:0]  tgt_offset_out;
  logic [7:0]  rx_pop_out, tx_push_out, g_pop, g_push;
  logic [5:0]  ep [8] = '{default: 6'h00};
  int          miscompares = 0, comparisons = 0;
  uart_window_decoder u_dut (.sys_clk_in, .rst_n_in, .base_addr_in, .mem_enable_in, .req_valid_in, .req_ready_out,
    .req_hit_out, .req_write_in, .req_addr_in, .req_be_in, .req_wdata_in, .resp_valid_out, .resp_rdata_out,
    .resp_misuse_out, .tgt_valid_out, .tgt_kind_out, .tgt_chan_out, .tgt_offset_out, .tgt_write_out, .tgt_be_out,
    .tgt_wdata_out, .tgt_rdata_in, .rx_pop_out, .rx_pop_count_out, .rx_bytes_in, .line_status_value_in,
    .tx_push_out, .tx_push_count_out, .tx_bytes_out);
  queue_side_model u_far (.sys_clk_in, .tgt_chan_in(tgt_chan_out), .tgt_offset_in(tgt_offset_out),
    .rx_pop_in(rx_pop_out), .rx_pop_count_in(rx_pop_count_out), .tgt_rdata_out(tgt_rdata_in),
    .rx_bytes_out(rx_bytes_in), .line_status_out(line_status_value_in));
  always #20 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] qb(input logic [2:0] c, input int k);
    return {c[1:0], 6'(ep[c] + k)};
  endfunction : qb
  // one request; strobes caught in the issue cycle
  task automatic acc(input logic wr, input logic [11:0] off, input logic [3:0] be, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= wr;
    req_addr_in <= {base_addr_in, off[11:2]};
    req_be_in <= be;
    req_wdata_in <= wd;
    @(posedge sys_clk_in);
    while (!(req_ready_out && req_hit_out) && n < 20)
    begin
      n++;
      @(posedge sys_clk_in);
    end
    req_valid_in <= 1'b0;
    @(negedge sys_clk_in);
    {g_kind, g_pop, g_pc, g_push, g_tc, g_tx} = {tgt_kind_out, rx_pop_out, rx_pop_count_out, tx_push_out,
      tx_push_count_out, tx_bytes_out};
    g_tgt = {tgt_valid_out, tgt_write_out, tgt_be_out, tgt_chan_out, tgt_offset_out};
    g_wd = tgt_wdata_out;
    chk({30'h0, req_ready_out, resp_valid_out}, 32'h0);
    @(negedge sys_clk_in);
    chk({31'h0, resp_valid_out}, 32'h1);
    g_rd = resp_rdata_out;
    g_mis = resp_misuse_out;
  endtask : acc
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    acc(1'b0, 12'h604, 4'hf, 32'h0);
    chk(g_rd, {20'h5a5a5, 3'h3, 9'h004});
    acc(1'b1, 12'h20a, 4'hc, 32'hbeef_0000);
    chk(32'(g_tgt), {14'h0, 1'b1, 1'b1, 4'hc, 3'h1, 9'h008});
    chk(g_wd, 32'hbeef_0000);
    chk(g_rd, 32'h0);
    acc(1'b0, 12'h08c, 4'hf, 32'h0);
    chk(32'(g_kind), 32'(KIND_CFG));
    acc(1'b0, 12'ha8c, 4'hf, 32'h0);
    chk({31'h0, g_mis}, 32'h1);
    acc(1'b0, 12'h150, 4'hf, 32'h0);
    chk({g_rd[31:1], g_mis}, 32'h1);
  endtask : t_regs
  task automatic t_rxq();
    acc(1'b0, 12'h500, 4'hf, 32'h0);
    chk(g_rd, {qb(2, 3), qb(2, 2), qb(2, 1), qb(2, 0)});
    chk({g_pop, 5'h0, g_pc}, 32'h0404);
    ep[2] += 4;
    acc(1'b0, 12'h53c, 4'h8, 32'h0);
    chk(g_rd, {qb(2, 0), 24'h0});
    chk({29'h0, g_pc}, 32'h1);
    ep[2] += 1;
  endtask : t_rxq
  task automatic t_txq();
    acc(1'b1, 12'hf00, 4'h6, 32'h4433_2211);
    chk({g_push, g_pop, 13'h0, g_tc}, 32'h8000_0002);
    chk({16'h0, g_tx[15:0]}, 32'h3322);
  endtask : t_txq
  task automatic t_err();
    acc(1'b0, 12'h380, 4'hf, 32'h0);
    chk(g_rd, {~qb(1, 1), qb(1, 1), ~qb(1, 0), qb(1, 0)});
    chk({29'h0, g_pc}, 32'h2);
    ep[1] += 2;
    acc(1'b0, 12'h3fc, 4'hc, 32'h0);
    chk(g_rd, {~qb(1, 0), qb(1, 0), 16'h0});
    ep[1] += 1;
    acc(1'b0, 12'h380, 4'h1, 32'h0);
    chk({g_pop, 23'h0, g_mis}, 32'h1);
    acc(1'b1, 12'h380, 4'hf, 32'h1234_5678);
    chk({g_push, 23'h0, g_mis}, 32'h1);
  endtask : t_err
  task automatic t_miss();
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_addr_in <= {20'hfeb01, 10'h0};
    repeat (3) @(negedge sys_clk_in);
    chk({31'h0, req_hit_out}, 32'h0);
    @(posedge sys_clk_in);
    req_addr_in <= {base_addr_in, 10'h0};
    mem_enable_in <= 1'b0;
    @(negedge sys_clk_in);
    chk({31'h0, req_hit_out}, 32'h0);
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    mem_enable_in <= 1'b1;
    base_addr_in <= 20'h12345;
    acc(1'b0, 12'he00, 4'hf, 32'h0);
    chk(g_rd, {20'h5a5a5, 3'h7, 9'h000});
  endtask : t_miss
  // reset lands in the issue cycle of a taken read
  task automatic t_reset();
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= 1'b0;
    req_addr_in <= {base_addr_in, 10'h0};
    req_be_in <= 4'hf;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    rst_n_in <= 1'b0;
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(negedge sys_clk_in);
    chk(resp_rdata_out, 32'h0);
    chk({22'h0, req_ready_out, resp_valid_out, rx_pop_out}, 32'h200);
    acc(1'b0, 12'he04, 4'hf, 32'h0);
    chk(g_rd, {20'h5a5a5, 3'h7, 9'h004});
  endtask : t_reset
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_rxq();
    t_txq();
    t_err();
    t_miss();
    t_reset();
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk_in);
    miscompares++;
    give_verdict();
  end
endmodule : tb_octal_uart_memory_map_decoder
